// *** verilog/dbpr_pkg.sv ***
/*
  Shared constants and carrier types of the double-buffered pixel reader.
  Assumes a single 125 MHz system clock and a 32-bit APB register bus.
*/
package dbpr_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [31:0] FRONT_ADDR = 32'hff203020;
  localparam logic [31:0] NEXT_ADDR = 32'hff203024;
  localparam logic [31:0] DIM_ADDR = 32'hff203028;
  localparam logic [31:0] STATE_ADDR = 32'hff20302c;
  localparam logic [31:0] EV_STS_ADDR = 32'hff203030;
  localparam logic [31:0] EV_MASK_ADDR = 32'hff203034;

  // ==========================================================
  // Reset values and command codes
  localparam logic [31:0] FRAME_RESET = 32'hc8000000;
  localparam logic [31:0] SWAP_CMD = 32'h00000001;
  localparam logic EN_RESET = 1'b1;

  // ==========================================================
  // Field positions of the state, command and dimension words
  localparam int ST_SWAP = 0;
  localparam int ST_LINEAR = 1;
  localparam int ST_EN = 2;
  localparam int ST_SB_LSB = 6;
  localparam int ST_BS_LSB = 8;
  localparam int ST_N_LSB = 16;
  localparam int ST_M_LSB = 24;
  localparam int DIM_Y_LSB = 16;

  // ==========================================================
  // Event bits of the interrupt status and mask words
  localparam int EV_FRAME = 0;
  localparam int EV_SWAP = 1;
  localparam int EV_NUM = 2;

  // ==========================================================
  // Geometry
  localparam int X_BITS = 9;
  localparam int Y_BITS = 8;
  localparam logic [9:0] SRC_W = 10'h140;
  localparam logic [9:0] SRC_H = 10'h0f0;
  localparam logic [9:0] SCR_W = 10'h280;
  localparam logic [9:0] SCR_H = 10'h1e0;
  localparam logic [9:0] H_TOTAL = 10'h320;
  localparam logic [9:0] V_TOTAL = 10'h20d;
  localparam int PIX_W = 16;
  localparam int PIX_BYTE_BITS = 1;

  // ==========================================================
  // Timing: pixel rate derived from the system clock
  localparam int CLK_HZ = 125000000;
  localparam int PIX_HZ = 25000000;
  localparam int PIX_DIV = CLK_HZ / PIX_HZ;
  localparam int DIV_W = 3;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } dbpr_apb_req_s;

  typedef struct packed {
    logic ack;
    logic [PIX_W-1:0] rdata;
  } dbpr_mem_rsp_s;

  typedef struct packed {
    logic valid;
    logic sof;
    logic [PIX_W-1:0] data;
  } dbpr_pix_s;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [9:0] h;
    logic [9:0] v;
    logic [31:0] front;
    logic [31:0] back;
    logic pend;
    logic en;
    logic [EV_NUM-1:0] sts;
    logic [EV_NUM-1:0] mask;
    logic req;
    logic [31:0] addr;
    logic [PIX_W-1:0] buf_px;
    dbpr_pix_s pix;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } dbpr_state_s;

endpackage

// *** verilog/dbpr_top.sv ***
/*
  Double-buffered pixel reader: APB registers, 640x480 raster timing,
  pixel fetch from frame memory with 2x2 replication, deferred pointer swap.
  Assumes frame memory answers a fetch within two pixel periods (10 clocks)
  and that all inputs come from logic on clk_in.
*/
`timescale 1ns/1ps
module dbpr_top #(
  parameter logic LINEAR_ADDR = 1'b0,
  parameter int SYMBOL_BITS = 8,
  parameter int BEAT_SYMBOLS = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire dbpr_pkg::dbpr_apb_req_s apb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic mem_req_out,
  output logic [31:0] mem_addr_out,
  input wire dbpr_pkg::dbpr_mem_rsp_s mem_in,
  output dbpr_pkg::dbpr_pix_s pix_out,
  output logic irq_out
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] pix_addr(input logic [31:0] base, input logic [9:0] sx,
                                           input logic [9:0] sy, input logic linear);
    logic [31:0] idx;
    idx = 32'({22'h0, sy} * 32'(dbpr_pkg::SRC_W)) + {22'h0, sx};
    if (linear) begin
      pix_addr = base + 32'(idx << dbpr_pkg::PIX_BYTE_BITS);
    end else begin
      pix_addr = base + {14'h0, sy[7:0], sx[8:0], 1'b0};
    end
  endfunction

  function automatic logic hit(input logic [31:0] a, input logic [31:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  dbpr_pkg::dbpr_state_s q, d;
  logic tick;
  logic acc;
  logic wr;
  logic rd;
  logic frame_end;
  logic active;
  logic [9:0] nh;
  logic [9:0] nv;
  logic [31:0] state_word;
  logic [31:0] dim_word;
  logic swap_req;
  logic mapped;

  // ==========================================================
  // Read-only words
  always_comb begin
    state_word = 32'h0;
    state_word[dbpr_pkg::ST_SWAP] = q.pend;
    state_word[dbpr_pkg::ST_LINEAR] = LINEAR_ADDR;
    state_word[dbpr_pkg::ST_EN] = q.en;
    state_word[dbpr_pkg::ST_SB_LSB +: 2] = 2'(BEAT_SYMBOLS - 1);
    state_word[dbpr_pkg::ST_BS_LSB +: 4] = 4'(SYMBOL_BITS - 1);
    state_word[dbpr_pkg::ST_N_LSB +: 8] = 8'(dbpr_pkg::X_BITS);
    state_word[dbpr_pkg::ST_M_LSB +: 8] = 8'(dbpr_pkg::Y_BITS);
    dim_word = {6'h0, dbpr_pkg::SRC_H, 6'h0, dbpr_pkg::SRC_W};
  end

  // ==========================================================
  // Bus decode and raster strobes
  always_comb begin
    acc = apb_in.psel & apb_in.penable & q.pready;
    wr = acc & apb_in.pwrite;
    rd = apb_in.psel & apb_in.penable & ~q.pready & ~apb_in.pwrite;
    mapped = hit(apb_in.paddr, dbpr_pkg::FRONT_ADDR) | hit(apb_in.paddr, dbpr_pkg::NEXT_ADDR)
           | hit(apb_in.paddr, dbpr_pkg::DIM_ADDR) | hit(apb_in.paddr, dbpr_pkg::STATE_ADDR)
           | hit(apb_in.paddr, dbpr_pkg::EV_STS_ADDR) | hit(apb_in.paddr, dbpr_pkg::EV_MASK_ADDR);
    swap_req = wr & hit(apb_in.paddr, dbpr_pkg::FRONT_ADDR) & (apb_in.pwdata == dbpr_pkg::SWAP_CMD);
    tick = (q.div == dbpr_pkg::DIV_W'(dbpr_pkg::PIX_DIV - 1));
    frame_end = tick && (q.h == dbpr_pkg::SCR_W - 10'h1) && (q.v == dbpr_pkg::SCR_H - 10'h1);
    active = (q.h < dbpr_pkg::SCR_W) && (q.v < dbpr_pkg::SCR_H);
    // Position two pixels ahead, wrapping into the next line and frame
    if (q.h >= dbpr_pkg::H_TOTAL - 10'h2) begin
      nh = q.h + 10'h2 - dbpr_pkg::H_TOTAL;
      nv = (q.v == dbpr_pkg::V_TOTAL - 10'h1) ? 10'h0 : q.v + 10'h1;
    end else begin
      nh = q.h + 10'h2;
      nv = q.v;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    // Pixel-rate divider and raster counters
    d.div = tick ? '0 : q.div + dbpr_pkg::DIV_W'(1);
    if (tick) begin
      if (q.h == dbpr_pkg::H_TOTAL - 10'h1) begin
        d.h = 10'h0;
        d.v = (q.v == dbpr_pkg::V_TOTAL - 10'h1) ? 10'h0 : q.v + 10'h1;
      end else begin
        d.h = q.h + 10'h1;
      end
    end

    // Pixel output: new source pixel on even columns, repeated on odd ones
    if (tick) begin
      d.pix.valid = active;
      d.pix.sof = (q.h == 10'h0) && (q.v == 10'h0);
      if (!active) begin
        d.pix.data = '0;
      end else if (!q.h[0]) begin
        d.pix.data = q.en ? q.buf_px : '0;
      end
    end

    // Memory fetch, two screen columns ahead of the display
    if (mem_in.ack && q.req) begin
      d.req = 1'b0;
      d.buf_px = mem_in.rdata;
    end
    if (tick && q.en && !q.req && !nh[0] && nh < dbpr_pkg::SCR_W && nv < dbpr_pkg::SCR_H) begin
      d.req = 1'b1;
      d.addr = pix_addr(q.front, {1'b0, nh[9:1]}, {1'b0, nv[9:1]}, LINEAR_ADDR);
    end

    // Pointer exchange at frame end, before any fetch of the next frame
    if (frame_end && q.pend) begin
      d.front = q.back;
      d.back = q.front;
      d.pend = 1'b0;
    end

    // Event flags: set wins over write-one-to-clear
    if (wr && hit(apb_in.paddr, dbpr_pkg::EV_STS_ADDR)) begin
      d.sts = q.sts & ~apb_in.pwdata[dbpr_pkg::EV_NUM-1:0];
    end
    if (frame_end) begin
      d.sts[dbpr_pkg::EV_FRAME] = 1'b1;
    end
    if (frame_end && q.pend) begin
      d.sts[dbpr_pkg::EV_SWAP] = 1'b1;
    end
    d.irq = |(d.sts & q.mask);

    // Register writes
    if (swap_req) begin
      d.pend = 1'b1;
    end
    if (wr && hit(apb_in.paddr, dbpr_pkg::NEXT_ADDR) && !(frame_end && q.pend)) begin
      d.back = apb_in.pwdata;
    end
    if (wr && hit(apb_in.paddr, dbpr_pkg::STATE_ADDR)) begin
      d.en = apb_in.pwdata[dbpr_pkg::ST_EN];
    end
    if (wr && hit(apb_in.paddr, dbpr_pkg::EV_MASK_ADDR)) begin
      d.mask = apb_in.pwdata[dbpr_pkg::EV_NUM-1:0];
      d.irq = |(d.sts & apb_in.pwdata[dbpr_pkg::EV_NUM-1:0]);
    end

    // APB answer: one wait state, registered data and error
    d.pready = apb_in.psel & apb_in.penable & ~q.pready;
    d.pslverr = apb_in.psel & apb_in.penable & ~q.pready & ~mapped;
    d.prdata = 32'h0;
    if (rd) begin
      unique case (1'b1)
        hit(apb_in.paddr, dbpr_pkg::FRONT_ADDR): d.prdata = q.front;
        hit(apb_in.paddr, dbpr_pkg::NEXT_ADDR): d.prdata = q.back;
        hit(apb_in.paddr, dbpr_pkg::DIM_ADDR): d.prdata = dim_word;
        hit(apb_in.paddr, dbpr_pkg::STATE_ADDR): d.prdata = state_word;
        hit(apb_in.paddr, dbpr_pkg::EV_STS_ADDR): d.prdata = {30'h0, q.sts};
        hit(apb_in.paddr, dbpr_pkg::EV_MASK_ADDR): d.prdata = {30'h0, q.mask};
        default: d.prdata = 32'h0;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
      q.front <= dbpr_pkg::FRAME_RESET;
      q.back <= dbpr_pkg::FRAME_RESET;
      q.en <= dbpr_pkg::EN_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state flops
  assign prdata_out = q.prdata;
  assign pready_out = q.pready;
  assign pslverr_out = q.pslverr;
  assign mem_req_out = q.req;
  assign mem_addr_out = q.addr;
  assign pix_out = q.pix;
  assign irq_out = q.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence swap_written;
    swap_req;
  endsequence

  sequence swap_flag_set;
    ##1 q.pend;
  endsequence

  swap_flag_set_a: assert property (swap_written |-> swap_flag_set)
    else $error("swap request did not raise pending flag");

  swap_wait_a: assert property (q.pend && !frame_end |=> q.pend)
    else $error("pending swap cleared before frame end");

  swap_exchange_a: assert property (frame_end && q.pend |=> q.front == $past(q.back)
                                    && q.back == $past(q.front) && !q.pend == !$past(swap_req))
    else $error("pointers not exchanged at frame end");

  front_keep_a: assert property (!(frame_end && q.pend) |=> q.front == $past(q.front))
    else $error("front pointer changed outside a swap");

  fetch_stop_a: assert property (!q.en && !q.req |=> !q.req)
    else $error("fetch issued while disabled");

  frame_end_pos_a: assert property (frame_end |-> q.h == 10'h27f && q.v == 10'h1df)
    else $error("frame end at wrong raster position");

  // Odd column tick comes five clocks after the even one and keeps the data
  pix_pair_a: assert property (tick && active && !q.h[0]
                               |-> ##6 q.pix.data == $past(q.pix.data))
    else $error("pixel not repeated on odd column");

  addr_xy_a: assert property ($rose(q.req) && !LINEAR_ADDR |-> q.addr[0] == 1'b0
                              && q.addr[31:18] == q.front[31:18])
    else $error("pixel address outside frame in x/y mode");

  irq_level_a: assert property (##1 q.irq == |($past(d.sts) & $past(d.mask)))
    else $error("interrupt level does not follow status and mask");

  apb_wait_a: assert property (apb_in.psel && apb_in.penable && !q.pready |=> q.pready ##1 !q.pready)
    else $error("apb ready not a single cycle after one wait");

  // ==========================================================
  // Bus answer checks

  // Ready stands for one cycle only
  ready_pulse_a: assert property (q.pready |=> !q.pready)
    else $error("apb ready held longer than one cycle");

  // Error only ever comes together with ready
  err_with_ready_a: assert property (q.pslverr |-> q.pready)
    else $error("apb error without ready");

  // Read data is zero outside the answer cycle
  rdata_idle_a: assert property (!q.pready |-> q.prdata == 32'h0)
    else $error("read data driven outside answer cycle");

  // Accepted write to the back pointer outside a swap cycle
  sequence back_written;
    wr && hit(apb_in.paddr, dbpr_pkg::NEXT_ADDR) && !(frame_end && q.pend);
  endsequence

  // Accepted write to the command word
  sequence en_written;
    wr && hit(apb_in.paddr, dbpr_pkg::STATE_ADDR);
  endsequence

  // Read of the state word in its wait cycle
  sequence state_read;
    rd && hit(apb_in.paddr, dbpr_pkg::STATE_ADDR);
  endsequence

  // Back pointer takes the written word
  back_write_a: assert property (back_written |=> q.back == $past(apb_in.pwdata))
    else $error("back pointer did not take written word");

  // Run enable follows its command bit
  en_write_a: assert property (en_written |=> q.en == $past(apb_in.pwdata[dbpr_pkg::ST_EN]))
    else $error("run enable did not follow command write");

  // State word answer shows the run enable in force
  state_en_a: assert property (state_read |=> q.prdata[dbpr_pkg::ST_EN] == $past(q.en))
    else $error("state word enable field wrong");

  // State word answer shows the addressing mode
  state_mode_a: assert property (state_read |=> q.prdata[dbpr_pkg::ST_LINEAR] == LINEAR_ADDR)
    else $error("state word mode field wrong");

  // ==========================================================
  // Fetch checks

  // Request and address hold until the memory answers
  req_hold_a: assert property (q.req && !mem_in.ack |=> q.req && $stable(q.addr))
    else $error("fetch request dropped before answer");

  // Request falls right after the answer
  req_drop_a: assert property (q.req && mem_in.ack |=> !q.req)
    else $error("fetch request held after answer");

  // A new fetch only starts while enabled
  fetch_en_a: assert property ($rose(q.req) |-> $past(q.en))
    else $error("fetch started while disabled");

  // ==========================================================
  // Raster and pixel checks

  // One pixel tick
  sequence pixel_tick;
    tick;
  endsequence

  // Four quiet clocks, then the next tick
  sequence quiet_then_tick;
    !tick [*4] ##1 tick;
  endsequence

  // Pixel rate is one tick every five clocks
  tick_cadence_a: assert property (pixel_tick |=> quiet_then_tick)
    else $error("pixel tick cadence wrong");

  // Raster counters stay inside the full raster
  raster_range_a: assert property (q.h < dbpr_pkg::H_TOTAL && q.v < dbpr_pkg::V_TOTAL)
    else $error("raster counter out of range");

  // Frame start marks a visible pixel
  sof_valid_a: assert property (q.pix.sof |-> q.pix.valid)
    else $error("frame start on a blank pixel");

  // Disabled reader shows dark pixels
  dark_pixel_a: assert property (tick && active && !q.h[0] && !q.en |=> q.pix.data == 16'h0)
    else $error("pixel shown while disabled");

  // ==========================================================
  // Swap and event checks

  // Pending flag clears only at a frame end
  pend_clear_a: assert property ($fell(q.pend) |-> $past(frame_end))
    else $error("pending flag cleared away from frame end");

  // Frame end always raises its event bit
  frame_ev_a: assert property (frame_end |=> q.sts[dbpr_pkg::EV_FRAME])
    else $error("frame end event not raised");

  // Completed swap raises its event bit
  swap_ev_a: assert property (frame_end && q.pend |=> q.sts[dbpr_pkg::EV_SWAP])
    else $error("swap done event not raised");

  // No interrupt while every event is masked
  irq_mask_off_a: assert property (q.mask == 2'h0 |-> !q.irq)
    else $error("interrupt raised while fully masked");

endmodule // dbpr_top

// *** verification/dbpr_mem_model.sv ***
/*
  Frame memory model that answers the reader's pixel fetches.
  Assumes fetches are held until ack; the bench sets the latency.
*/
`timescale 1ns/1ps
module dbpr_mem_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_in,
  input wire logic [31:0] addr_in,
  input wire logic [3:0] lat_in,
  output dbpr_pkg::dbpr_mem_rsp_s rsp_out
);
  logic [3:0] wait_q;
  // ==========================================================
  // Ack a held fetch after lat_in cycles; data only valid on ack
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_q <= 4'h0;
      rsp_out <= '0;
    end else begin
      rsp_out.ack <= req_in && !rsp_out.ack && wait_q >= lat_in;
      wait_q <= (req_in && !rsp_out.ack) ? wait_q + 4'h1 : 4'h0;
      // Idle data toggles so a stale sample cannot pass
      rsp_out.rdata <= (req_in && !rsp_out.ack && wait_q >= lat_in) ? (addr_in[16:1] ^ 16'h3c5a) : ~rsp_out.rdata;
    end
  end
endmodule // dbpr_mem_model

// *** verification/testbench.sv ***
/*
  Self-checking bench of the pixel reader: APB register tests, pixel stream
  and fetch checks. Assumes dbpr_pkg and the memory model are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  logic clk_in, rst_n_in, pready_out, pslverr_out, mem_req_out, irq_out, er, req_d, seen;
  dbpr_pkg::dbpr_apb_req_s apb_in;
  dbpr_pkg::dbpr_mem_rsp_s mem_in;
  dbpr_pkg::dbpr_pix_s pix_out;
  logic [31:0] prdata_out, mem_addr_out, rd, ea;
  logic [3:0] lat_q;
  int n_errors, samples_checked, pc, fetches, bad_px;
  localparam logic [31:0] ST = {8'h08, 8'h09, 4'h0, 4'h7, 2'h1, 3'h0, 1'b1, 1'b0, 1'b0};
  localparam logic [31:0] DIM = {6'h0, 10'h0f0, 6'h0, 10'h140};

  dbpr_top dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .apb_in(apb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .mem_req_out(mem_req_out),
    .mem_addr_out(mem_addr_out), .mem_in(mem_in), .pix_out(pix_out), .irq_out(irq_out));
  dbpr_mem_model mem (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(mem_req_out),
    .addr_in(mem_addr_out), .lat_in(lat_q), .rsp_out(mem_in));

  // ==========================================================
  // Comparison, verdict and bus tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic xe);
    int n;
    logic p;
    n = 0;
    @(posedge clk_in);
    apb_in <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_in);
    apb_in.penable <= 1'b1;
    // Hold the request until ready is sampled high at a rising edge
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    p = pready_out;
    rd = prdata_out;
    er = pslverr_out;
    apb_in <= '{1'b0, 1'b0, w, a, d};
    chk("pready", 32'h1, {31'h0, p});
    chk("pslverr", {31'h0, xe}, {31'h0, er});
  endtask

  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(nm, e, rd);
  endtask

  // ==========================================================
  // Clock, memory latency and watchdog
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  initial begin
    lat_q = 4'h1;
    wait (pc >= 4800);
    @(posedge clk_in);
    lat_q <= 4'h6;
  end

  initial begin
    repeat (60000) @(posedge clk_in);
    n_errors++;
    $display("BAD watchdog expired");
    end_of_test();
  end

  // ==========================================================
  // Fetch counter and pixel stream monitor
  always @(negedge clk_in) begin
    if (mem_req_out === 1'b1 && req_d !== 1'b1) fetches++;
    req_d = mem_req_out;
    if (pix_out.valid === 1'b1) begin
      if (pix_out.data !== 16'h0) bad_px++;
      if (pix_out.sof === 1'b1) seen = 1'b1;
      if (seen && pc < 9600) begin
        ea = dbpr_pkg::FRAME_RESET + (((pc / 3200) / 2) << 10) + (((pc % 3200) / 10) << 1);
        if (pc >= 3200) chk("pixel", {16'h0, ea[16:1] ^ 16'h3c5a}, {16'h0, pix_out.data});
        pc++;
      end
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_n_in = 1'b0;
    apb_in = '0;
    {n_errors, samples_checked, pc, fetches, bad_px} = '0;
    {req_d, seen} = 2'b00;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rdc("front", dbpr_pkg::FRONT_ADDR, dbpr_pkg::FRAME_RESET);
    rdc("back", dbpr_pkg::NEXT_ADDR, dbpr_pkg::FRAME_RESET);
    rdc("dim", dbpr_pkg::DIM_ADDR, DIM);
    rdc("state", dbpr_pkg::STATE_ADDR, ST);
    rdc("ev_sts", dbpr_pkg::EV_STS_ADDR, 32'h0);
    rdc("ev_mask", dbpr_pkg::EV_MASK_ADDR, 32'h0);
    apb(1'b0, 32'hff203038, 32'h0, 1'b1);
    chk("unmapped", 32'h0, rd);
    apb(1'b1, dbpr_pkg::NEXT_ADDR, 32'hc0001000, 1'b0);
    rdc("back_wr", dbpr_pkg::NEXT_ADDR, 32'hc0001000);
    apb(1'b1, dbpr_pkg::FRONT_ADDR, 32'h00000005, 1'b0);
    rdc("front_ro", dbpr_pkg::FRONT_ADDR, dbpr_pkg::FRAME_RESET);
    apb(1'b1, dbpr_pkg::DIM_ADDR, 32'h0, 1'b0);
    rdc("dim_ro", dbpr_pkg::DIM_ADDR, DIM);
    apb(1'b1, dbpr_pkg::FRONT_ADDR, dbpr_pkg::SWAP_CMD, 1'b0);
    rdc("front_swp", dbpr_pkg::FRONT_ADDR, dbpr_pkg::FRAME_RESET);
    rdc("pending", dbpr_pkg::STATE_ADDR, ST | 32'h1);
    apb(1'b1, dbpr_pkg::EV_MASK_ADDR, 32'h3, 1'b0);
    rdc("mask_wr", dbpr_pkg::EV_MASK_ADDR, 32'h3);
    apb(1'b1, dbpr_pkg::EV_STS_ADDR, 32'h3, 1'b0);
    rdc("ev_clr", dbpr_pkg::EV_STS_ADDR, 32'h0);
    chk("irq", 32'h0, {31'h0, irq_out});
    wait (pc >= 9600);
    // Stop fetching, then let it run again
    apb(1'b1, dbpr_pkg::STATE_ADDR, 32'h0, 1'b0);
    rdc("state_off", dbpr_pkg::STATE_ADDR, ST & 32'hfffffffb | 32'h1);
    repeat (20) @(posedge clk_in);
    {fetches, bad_px} = '0;
    repeat (8000) @(posedge clk_in);
    chk("fetch_off", 32'h0, fetches);
    chk("px_off", 32'h0, bad_px);
    apb(1'b1, dbpr_pkg::STATE_ADDR, 32'h4, 1'b0);
    repeat (4000) @(posedge clk_in);
    fetches = 0;
    repeat (8000) @(posedge clk_in);
    chk("fetch_rate", 32'd640, fetches);
    rdc("still_pend", dbpr_pkg::STATE_ADDR, ST | 32'h1);
    rdc("front_hold", dbpr_pkg::FRONT_ADDR, dbpr_pkg::FRAME_RESET);
    end_of_test();
  end
endmodule // testbench
